/* core/fmc_master_config.sv */
// master configuration logic of one framer: registers, resets, power-down, clock and
// loopback steering, unframed ones, counter update timing and transmit pin inversion.
// assumes line clocks and line pins arrive asynchronously and run well below CLK/2.
// Operation
// (R1) writing one to soft reset returns all other registers to defaults
// (R2) host holds soft reset high at least 100 ns, then clears it
// (R3) effective framer reset is soft reset bit OR the reset pin
// (R4) power-down bit stops the framer clocks; clearing it restarts them
// (R5) after power-up the host toggles soft reset to reinitialise
// (R6) toggling soft reset while powered down re-enables the framer
// (R7) unframed ones bit, set at reset, sends continuous unframed all ones
// (R8) auto mode latches counters each second and sets the tick flag
// (R9) in manual mode a rising edge on pin or bit latches counters
// (R10) host waits 100 ns after a manual update before reading counters
// (R11) manual bit ignored in auto mode; host clears and re-sets it
// (R12) line mode bit picks dual rail or binary with violation pulses
// (R13) zero substitution on unless disabled; always off in binary mode
// (R14) stalled transmit clock flags loss; fallback uses receive clock, sends AIS
// (R15) payload loopback runs transmit from receive clock and receive data
// (R16) line loopback sends receive pins and clock to transmit pins
// (R17) line and diagnostic loopback may be active together
// (R18) diagnostic loopback feeds receive framer from pre-insertion transmit data
// (R19) constant clock bit puts transmit clock on enable pin, inversion kept
// (R20) one-second timer clocked by receive or transmit input clock
// (R21) three bits invert enable pin, transmit data and transmit input clock
// (R22) read-only identification register at offset zero
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
module fmc_master_config
  import fmc_pkg::*;
#(
  parameter logic [SEC_W-1:0] ONE_SECOND_EDGES = ONE_SECOND_EDGES_DEFAULT,
  parameter logic [7:0]       IDENT_CODE       = 8'h5A   // arbitrary value
) (
  input  wire logic       CLK,
  input  wire logic       RESET_N,
  input  wire fmc_bus_s   BUS,
  output logic [7:0]      RD_DATA,
  input  wire logic       FRAMER_RST_PIN,
  input  wire logic       TX_INPUT_CLOCK,
  input  wire logic       TX_PAYLOAD_IN,
  input  wire logic       RX_LINE_CLOCK,
  input  wire fmc_rails_s RX_RAIL,
  input  wire logic       EXT_COUNTER_UPDATE_IN,
  input  wire fmc_rails_s FMT_LINE,
  input  wire fmc_rails_s FMT_AIS,
  input  wire logic       FMT_PAYLOAD_SLOT,
  output fmc_rails_s      TX_RAIL,
  output logic            TX_LINE_CLOCK,
  output logic            TX_ENABLE_GAPPED_CLOCK_PIN,
  output logic            FMT_PAYLOAD,
  output logic            FMT_BIT_EN,
  output fmc_rails_s      RX_LINE,
  output logic            RX_BIT_EN,
  output logic            RX_CODE_VIOLATION,
  output logic            LINE_MODE_BINARY,
  output logic            ZERO_SUBST_ENABLE,
  output logic            FRAMER_RESET,
  output logic            FRAMER_CLK_EN,
  output logic            COUNTER_LATCH
);

  fmc_state_s s;
  fmc_state_s n;

  logic fr_reset;
  logic run;
  logic tx_lvl;
  logic tx_edge;
  logic tx_change;
  logic rx_lvl;
  logic rx_edge;
  logic fallback;
  logic use_rx;
  logic sel_lvl;
  logic sel_edge;
  logic sec_edge;
  logic sec_tick;
  logic ext_rise;
  logic manual_rise;
  logic auto_upd;
  logic manual_upd;
  logic binary;
  logic en_raw;

  assign fr_reset    = s.cfg1[B_SOFT_RESET] | s.frst_sy[1];                  // R3
  assign run         = ~s.cfg1[B_DISABLE];                                   // R4
  assign tx_lvl      = s.txclk_sy[1] ^ s.cfg3[B_CLK_INV];                    // R21
  assign tx_edge     = tx_lvl & ~(s.txclk_sy[2] ^ s.cfg3[B_CLK_INV]);
  assign tx_change   = s.txclk_sy[1] ^ s.txclk_sy[2];
  assign rx_lvl      = s.rxclk_sy[1];
  assign rx_edge     = s.rxclk_sy[1] & ~s.rxclk_sy[2];
  assign fallback    = s.cfg1[B_FALLBACK] & s.loss;                          // R14
  // payload loopback, clock fallback and line loopback all move transmit to rx clock
  assign use_rx      = s.cfg2[B_PAYLOAD_LB] | fallback | s.cfg2[B_LINE_LB];  // R15
  assign sel_lvl     = use_rx ? rx_lvl : tx_lvl;
  assign sel_edge    = use_rx ? rx_edge : tx_edge;
  assign sec_edge    = s.cfg2[B_SEC_SEL] ? tx_edge : rx_edge;                // R20
  assign sec_tick    = run & sec_edge & (s.sec_cnt == ONE_SECOND_EDGES - SEC_W'(1));
  assign ext_rise    = s.ecu_sy[1] & ~s.ecu_sy[2];
  assign manual_rise = s.cfg1[B_MANUAL] & ~s.manual_prev;
  assign auto_upd    = ~s.cfg1[B_DEFEAT] & sec_tick;                          // R8
  assign manual_upd  = run & s.cfg1[B_DEFEAT] & (ext_rise | manual_rise);    // R9 R11
  assign binary      = s.cfg1[B_BINARY];
  // constant clock wins over the enable mode select
  assign en_raw      = s.cfg2[B_CONST_CLK] ? sel_lvl :                       // R19
                       (s.cfg3[B_EN_MODE] ? (sel_lvl & FMT_PAYLOAD_SLOT) : FMT_PAYLOAD_SLOT);

  always_comb begin
    n = s;
    // synchronisers: element 0 is read only by element 1
    n.txclk_sy    = {s.txclk_sy[1:0], TX_INPUT_CLOCK};
    n.rxclk_sy    = {s.rxclk_sy[1:0], RX_LINE_CLOCK};
    n.ecu_sy      = {s.ecu_sy[1:0], EXT_COUNTER_UPDATE_IN};
    n.frst_sy     = {s.frst_sy[0], FRAMER_RST_PIN};
    n.txdat_sy    = {s.txdat_sy[0], TX_PAYLOAD_IN};
    n.rx_s1       = RX_RAIL;
    n.rx_s2       = s.rx_s1;
    n.manual_prev = s.cfg1[B_MANUAL];
    n.latch       = auto_upd | manual_upd;                                   // R8 R9
    n.fmt_bit_en  = run & sel_edge;
    n.rx_bit_en   = 1'b0;
    n.rx_lcv      = 1'b0;

    // one-second timer
    if (run && sec_edge) begin
      n.sec_cnt = sec_tick ? '0 : s.sec_cnt + SEC_W'(1);                     // R20
    end

    // transmit input clock watchdog
    if (run) begin
      if (tx_change) begin
        n.loss_cnt = '0;
        n.loss     = 1'b0;
      end else if (s.loss_cnt >= LOSS_CYCLES - LOSS_W'(1)) begin
        n.loss     = 1'b1;                                                   // R14
      end else begin
        n.loss_cnt = s.loss_cnt + LOSS_W'(1);
      end
    end

    // register writes; sticky flags are write-one-to-clear and a set wins
    if (BUS.wr) begin
      case (BUS.addr)
        ADDR_CFG1: n.cfg1 = BUS.wdata;
        ADDR_CFG2: n.cfg2 = BUS.wdata & CFG2_MASK;
        ADDR_CFG3: n.cfg3 = BUS.wdata;
        ADDR_LATCHED: begin
          if (BUS.wdata[B_LOSS]) n.loss_l = 1'b0;
          if (BUS.wdata[B_TICK]) n.tick_l = 1'b0;
        end
        default: ;
      endcase
    end
    if (auto_upd) n.tick_l = 1'b1;                                           // R8
    if (n.loss && !s.loss) n.loss_l = 1'b1;                                  // R14

    // register reads, data valid the cycle after the strobe
    n.rdata = 8'h00;
    if (BUS.rd) begin
      case (BUS.addr)
        ADDR_IDENT:   n.rdata = IDENT_CODE;                                  // R22
        ADDR_CFG1:    n.rdata = s.cfg1;
        ADDR_CFG2:    n.rdata = s.cfg2;
        ADDR_CFG3:    n.rdata = s.cfg3;
        ADDR_STATUS:  n.rdata = {1'b0, s.loss, 6'h00};
        ADDR_LATCHED: n.rdata = {1'b0, s.loss_l, 5'h00, s.tick_l};
        default:      n.rdata = 8'h00;
      endcase
    end

    if (run) begin
      n.tx_clk_out = s.cfg2[B_LINE_LB] ? rx_lvl : sel_lvl;                   // R16
      n.tx_en_pin  = en_raw ^ s.cfg3[B_EN_INV];                              // R19 R21
    end

    // transmit line, updated on each selected transmit bit clock
    if (run && sel_edge) begin
      n.fmt_payload = s.cfg2[B_PAYLOAD_LB] ? s.rx_s2.pos                     // R15
                                           : (s.txdat_sy[1] ^ s.cfg3[B_DATA_INV]); // R21
      if (s.cfg2[B_LINE_LB]) begin
        n.tx_rail = s.rx_s2;                                                 // R16 R17
      end else if (s.cfg1[B_ONES]) begin
        // binary: steady one; dual rail: alternate marks
        n.ones_phase  = ~s.ones_phase;                                       // R7
        n.tx_rail.pos = binary | ~s.ones_phase;
        n.tx_rail.neg = ~binary & s.ones_phase;
      end else if (fallback) begin
        n.tx_rail = FMT_AIS;                                                 // R14
      end else begin
        n.tx_rail = FMT_LINE;
      end
    end

    // receive framer feed; payload loopback leaves it untouched
    if (run) begin
      if (s.cfg2[B_DIAG_LB]) begin
        // tap ahead of ones, AIS and pin-level treatment
        n.rx_line   = FMT_LINE;                                              // R18 R17
        n.rx_bit_en = sel_edge;
      end else if (rx_edge) begin
        n.rx_line   = s.rx_s2;
        n.rx_bit_en = 1'b1;
        n.rx_lcv    = binary & s.rx_s2.neg;                                  // R12
      end
    end

    // soft reset or reset pin: registers except the soft reset bit, flags, counters, rails and bit enables to default
    if (fr_reset) begin
      n.cfg1       = {CFG1_RESET[7:1], n.cfg1[B_SOFT_RESET]};               // R1 R6
      n.cfg2       = CFG2_RESET;
      n.cfg3       = CFG3_RESET;
      n.loss       = 1'b0;
      n.loss_l     = 1'b0;
      n.tick_l     = 1'b0;
      n.latch      = 1'b0;
      n.loss_cnt   = '0;
      n.sec_cnt    = '0;
      n.ones_phase = 1'b0;
      n.tx_rail    = '0;
      n.rx_line    = '0;
      n.fmt_bit_en = 1'b0;
      n.rx_bit_en  = 1'b0;
      n.rx_lcv     = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      s      <= '0;
      s.cfg1 <= CFG1_RESET;
    end else begin
      s <= n;
    end
  end

  assign RD_DATA                    = s.rdata;
  assign TX_RAIL                    = s.tx_rail;
  assign TX_LINE_CLOCK              = s.tx_clk_out;
  assign TX_ENABLE_GAPPED_CLOCK_PIN = s.tx_en_pin;
  assign FMT_PAYLOAD                = s.fmt_payload;
  assign FMT_BIT_EN                 = s.fmt_bit_en;
  assign RX_LINE                    = s.rx_line;
  assign RX_BIT_EN                  = s.rx_bit_en;
  assign RX_CODE_VIOLATION          = s.rx_lcv;
  assign LINE_MODE_BINARY           = binary;                                // R12
  assign ZERO_SUBST_ENABLE          = ~s.cfg1[B_ZS_DIS] & ~binary;           // R13
  assign FRAMER_RESET               = fr_reset;                              // R3
  assign FRAMER_CLK_EN              = run;                                   // R4
  assign COUNTER_LATCH              = s.latch;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  sequence s_soft_write;
    BUS.wr && BUS.addr == ADDR_CFG1 && BUS.wdata[B_SOFT_RESET];
  endsequence
  sequence s_defaults_back;
    s.cfg2 == CFG2_RESET && s.cfg3 == CFG3_RESET && s.cfg1[7:1] == CFG1_RESET[7:1];
  endsequence
  property p_soft_reset;
    s_soft_write ##1 (!BUS.wr)[*2] |-> s_defaults_back and s.cfg1[B_SOFT_RESET];
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset left a register set"); // R1

  property p_reset_or;
    (s.frst_sy[1] || s.cfg1[B_SOFT_RESET]) |-> FRAMER_RESET;
  endproperty
  a_reset_or: assert property (p_reset_or) else $error("framer reset missing a source"); // R3

  property p_powered_down;
    s.cfg1[B_DISABLE] && $past(s.cfg1[B_DISABLE]) |-> !FRAMER_CLK_EN && $stable(TX_RAIL)
      && !FMT_BIT_EN && !COUNTER_LATCH;
  endproperty
  a_powered_down: assert property (p_powered_down) else $error("disabled framer still runs"); // R4

  property p_unframed_binary;
    run && sel_edge && s.cfg1[B_ONES] && binary && !s.cfg2[B_LINE_LB] && !fr_reset
      |=> TX_RAIL.pos && !TX_RAIL.neg;
  endproperty
  a_unframed_binary: assert property (p_unframed_binary) else $error("all ones not sent"); // R7

  property p_auto_update;
    !s.cfg1[B_DEFEAT] && sec_tick && !fr_reset |=> COUNTER_LATCH && s.tick_l;
  endproperty
  a_auto_update: assert property (p_auto_update) else $error("second tick not latched"); // R8

  property p_manual_update;
    run && s.cfg1[B_DEFEAT] && ext_rise && !fr_reset |=> COUNTER_LATCH;
  endproperty
  a_manual_update: assert property (p_manual_update) else $error("manual update lost"); // R9

  property p_manual_ignored;
    !s.cfg1[B_DEFEAT] && !sec_tick |=> !COUNTER_LATCH;
  endproperty
  a_manual_ignored: assert property (p_manual_ignored) else $error("update in auto mode"); // R11

  property p_fallback_ais;
    run && sel_edge && fallback && !s.cfg1[B_ONES] && !s.cfg2[B_LINE_LB] && !fr_reset
      |=> TX_RAIL == $past(FMT_AIS);
  endproperty
  a_fallback_ais: assert property (p_fallback_ais) else $error("fallback did not send AIS"); // R14

  property p_line_loop;
    run && rx_edge && s.cfg2[B_LINE_LB] && !fr_reset |=> TX_RAIL == $past(s.rx_s2)
      && TX_LINE_CLOCK == $past(rx_lvl);
  endproperty
  a_line_loop: assert property (p_line_loop) else $error("line loopback path broken"); // R16

  property p_diag_loop;
    run && s.cfg2[B_DIAG_LB] && !fr_reset |=> RX_LINE == $past(FMT_LINE);
  endproperty
  a_diag_loop: assert property (p_diag_loop) else $error("diagnostic tap wrong"); // R18

  property p_const_clock;
    run && s.cfg2[B_CONST_CLK] |=> TX_ENABLE_GAPPED_CLOCK_PIN == $past(sel_lvl ^ s.cfg3[B_EN_INV]);
  endproperty
  a_const_clock: assert property (p_const_clock) else $error("constant clock not on pin"); // R19

  sequence s_manual_rise;
    run && s.cfg1[B_DEFEAT] && manual_rise && !fr_reset;
  endsequence
  property p_manual_bit;
    s_manual_rise |=> COUNTER_LATCH;
  endproperty
  a_manual_bit: assert property (p_manual_bit) else $error("manual bit update lost"); // R9

  property p_reenable;
    fr_reset |=> !s.cfg1[B_DISABLE];
  endproperty
  a_reenable: assert property (p_reenable) else $error("framer reset left it disabled"); // R6

  property p_ident;
    BUS.rd && BUS.addr == ADDR_IDENT
      |=> RD_DATA == IDENT_CODE;
  endproperty
  a_ident: assert property (p_ident) else $error("identification read wrong"); // R22

  // receive feed and violation pulses share one trigger
  sequence s_rx_bit;
    run && rx_edge && !s.cfg2[B_DIAG_LB] && !fr_reset;
  endsequence
  property p_rx_feed;
    s_rx_bit |=> RX_BIT_EN
      && RX_LINE == $past(s.rx_s2);
  endproperty
  a_rx_feed: assert property (p_rx_feed) else $error("receive feed stalled"); // R16

  property p_violation;
    s_rx_bit ##0 (binary && s.rx_s2.neg)
      |=> RX_CODE_VIOLATION;
  endproperty
  a_violation: assert property (p_violation) else $error("violation pulse missing"); // R12

  property p_dual_quiet;
    !binary |=> !RX_CODE_VIOLATION;
  endproperty
  a_dual_quiet: assert property (p_dual_quiet) else $error("violation in dual rail"); // R12

  property p_payload_loop;
    run && sel_edge && s.cfg2[B_PAYLOAD_LB] && !fr_reset
      |=> FMT_PAYLOAD == $past(s.rx_s2.pos);
  endproperty
  a_payload_loop: assert property (p_payload_loop) else $error("payload not looped"); // R15

  // watchdog at its limit with no clock change must raise the loss flag
  property p_loss_flag;
    run && !tx_change && s.loss_cnt >= LOSS_CYCLES - LOSS_W'(1) && !fr_reset
      |=> s.loss;
  endproperty
  a_loss_flag: assert property (p_loss_flag) else $error("stalled clock not flagged"); // R14

endmodule

/* core/fmc_pkg.sv */
// package for the framer master configuration block: register map, field positions,
// reset values, timing constants and the carrier types.
// assumes a single 100 MHz system clock and an 8-bit register port.
package fmc_pkg;

  // register offsets
  localparam logic [7:0] ADDR_IDENT   = 8'h00;
  localparam logic [7:0] ADDR_CFG1    = 8'h01;
  localparam logic [7:0] ADDR_CFG2    = 8'h02;
  localparam logic [7:0] ADDR_CFG3    = 8'h03;
  localparam logic [7:0] ADDR_STATUS  = 8'h08;
  localparam logic [7:0] ADDR_LATCHED = 8'h09;

  // reset values and write mask
  localparam logic [7:0] CFG1_RESET = 8'h04;
  localparam logic [7:0] CFG2_RESET = 8'h00;
  localparam logic [7:0] CFG3_RESET = 8'h00;
  localparam logic [7:0] CFG2_MASK  = 8'hC7;

  // master_config_one fields
  localparam int B_SOFT_RESET = 0;
  localparam int B_DISABLE    = 1;
  localparam int B_ONES       = 2;
  localparam int B_DEFEAT     = 3;
  localparam int B_MANUAL     = 4;
  localparam int B_BINARY     = 5;
  localparam int B_ZS_DIS     = 6;
  localparam int B_FALLBACK   = 7;
  // master_config_two fields
  localparam int B_PAYLOAD_LB = 0;
  localparam int B_LINE_LB    = 1;
  localparam int B_DIAG_LB    = 2;
  localparam int B_CONST_CLK  = 6;
  localparam int B_SEC_SEL    = 7;
  // master_config_three fields
  localparam int B_EN_INV     = 0;
  localparam int B_DATA_INV   = 1;
  localparam int B_CLK_INV    = 2;
  localparam int B_EN_MODE    = 7;
  // status fields
  localparam int B_LOSS       = 6;
  localparam int B_TICK       = 0;

  // timing
  localparam int CLK_MHZ         = 100;
  localparam int SOFT_RESET_NS   = 100;
  localparam int UPDATE_WAIT_NS  = 100;
  localparam int LOSS_TIME_NS    = 1000;
  localparam int LOSS_W          = 8;
  localparam logic [LOSS_W-1:0] LOSS_CYCLES =
    LOSS_W'((LOSS_TIME_NS * CLK_MHZ + 999) / 1000);
  localparam int SEC_W           = 26;
  localparam logic [SEC_W-1:0] ONE_SECOND_EDGES_DEFAULT = 26'h2AA9E00;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } fmc_bus_s;

  typedef struct packed {
    logic pos;
    logic neg;
  } fmc_rails_s;

  typedef struct packed {
    logic [7:0]        cfg1;
    logic [7:0]        cfg2;
    logic [7:0]        cfg3;
    logic [7:0]        rdata;
    logic [2:0]        txclk_sy;
    logic [2:0]        rxclk_sy;
    logic [2:0]        ecu_sy;
    logic [1:0]        frst_sy;
    logic [1:0]        txdat_sy;
    fmc_rails_s        rx_s1;
    fmc_rails_s        rx_s2;
    logic              manual_prev;
    logic              loss;
    logic              loss_l;
    logic              tick_l;
    logic              latch;
    logic              ones_phase;
    logic [SEC_W-1:0]  sec_cnt;
    logic [LOSS_W-1:0] loss_cnt;
    fmc_rails_s        tx_rail;
    fmc_rails_s        rx_line;
    logic              tx_clk_out;
    logic              tx_en_pin;
    logic              fmt_payload;
    logic              fmt_bit_en;
    logic              rx_bit_en;
    logic              rx_lcv;
  } fmc_state_s;

endpackage

/* dv/fmc_liu_model.sv */
// line interface unit model: receive line clock and receive rails toward the framer.
// assumes the bench enables it only while a frame is meant to be on the line.
`timescale 1ns/1ps
module fmc_liu_model
  import fmc_pkg::*;
(
  input  wire logic       RUN,
  input  wire fmc_rails_s DATA,
  output logic            RX_LINE_CLOCK,
  output fmc_rails_s      RX_RAIL
);
  // 80 ns line clock; rails change on the falling edge, clock stands low when idle
  initial begin
    RX_LINE_CLOCK = 1'b0;
    RX_RAIL       = 2'h0;
    forever begin
      #40;
      if (RUN) begin
        RX_LINE_CLOCK = ~RX_LINE_CLOCK;
        if (!RX_LINE_CLOCK) begin
          RX_RAIL = DATA;
        end
      end else begin
        RX_LINE_CLOCK = 1'b0;
        // idle rails carry no data: keep them moving so stale values never pass
        RX_RAIL = ~RX_RAIL;
      end
    end
  end
endmodule

/* dv/fmc_master_config_tb.sv */
// self-checking bench for the framer master configuration block.
// assumes fmc_pkg and fmc_master_config from core/; the far side is fmc_liu_model.
`timescale 1ns/1ps
module fmc_master_config_tb;
  import fmc_pkg::*;
  logic       CLK, RESET_N, rst_pin, tx_clk, tx_run, rx_run, tx_pay, ecu, slot;
  fmc_bus_s   bus;
  fmc_rails_s rx_rail, rx_data, fmt_line, fmt_ais, tx_rail, rx_line;
  logic [7:0] rd_data;
  logic       rx_clk, tx_lclk, en_pin, fmt_pay, bit_en, rx_bit_en, lcv, line_mode_binary, zse;
  logic       frst, clk_en, latch;
  int         fails, compares;

  fmc_liu_model i_liu (.RUN(rx_run), .DATA(rx_data), .RX_LINE_CLOCK(rx_clk), .RX_RAIL(rx_rail));
  fmc_master_config #(.ONE_SECOND_EDGES(26'h0000010)) i_dut (
    .CLK(CLK), .RESET_N(RESET_N), .BUS(bus), .RD_DATA(rd_data), .FRAMER_RST_PIN(rst_pin),
    .TX_INPUT_CLOCK(tx_clk), .TX_PAYLOAD_IN(tx_pay), .RX_LINE_CLOCK(rx_clk),
    .RX_RAIL(rx_rail), .EXT_COUNTER_UPDATE_IN(ecu), .FMT_LINE(fmt_line), .FMT_AIS(fmt_ais),
    .FMT_PAYLOAD_SLOT(slot), .TX_RAIL(tx_rail), .TX_LINE_CLOCK(tx_lclk),
    .TX_ENABLE_GAPPED_CLOCK_PIN(en_pin), .FMT_PAYLOAD(fmt_pay), .FMT_BIT_EN(bit_en),
    .RX_LINE(rx_line), .RX_BIT_EN(rx_bit_en), .RX_CODE_VIOLATION(lcv),
    .LINE_MODE_BINARY(line_mode_binary), .ZERO_SUBST_ENABLE(zse), .FRAMER_RESET(frst),
    .FRAMER_CLK_EN(clk_en), .COUNTER_LATCH(latch));

  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  // transmit input clock, 80 ns, stands low while stopped
  initial begin
    tx_clk = 1'b0;
    forever begin
      #40;
      tx_clk = tx_run ? ~tx_clk : 1'b0;
    end
  end

  task automatic print_verdict();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.wr    <= 1'b1;
    @(posedge CLK);
    bus.wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge CLK);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge CLK);
    bus.rd   <= 1'b0;
    #1 d = rd_data;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(d & m, exp);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
  endtask

  // pulses of latch (0), violation (1), bit enable (2), receive bit enable (4);
  // changes of the enable pin (3) or the transmit line clock (5)
  task automatic count(input int which, input int cycles, output logic [7:0] n);
    logic prev;
    logic prev_clk;
    n        = 8'h00;
    prev     = en_pin;
    prev_clk = tx_lclk;
    repeat (cycles) begin
      @(posedge CLK);
      #1;
      case (which)
        0: n += {7'h00, latch};
        1: n += {7'h00, lcv};
        2: n += {7'h00, bit_en};
        4: n += {7'h00, rx_bit_en};
        5: begin
          n += {7'h00, tx_lclk !== prev_clk};
          prev_clk = tx_lclk;
        end
        default: begin
          n += {7'h00, en_pin !== prev};
          prev = en_pin;
        end
      endcase
    end
  endtask

  task automatic wait_bit();
    int i;
    for (i = 0; i < 60; i++) begin
      @(posedge CLK);
      #1;
      if (bit_en === 1'b1) break;
    end
    if (i == 60) chk(8'h00, 8'h01);
  endtask

  task automatic t_regs();
    rdc(ADDR_IDENT, 8'hFF, 8'h5A);
    rdc(ADDR_CFG1, 8'hFF, 8'h04);
    rdc(ADDR_CFG2, 8'hFF, 8'h00);
    rdc(ADDR_CFG3, 8'hFF, 8'h00);
    wr(ADDR_IDENT, 8'hFF);
    rdc(ADDR_IDENT, 8'hFF, 8'h5A);
    rdc(8'h07, 8'hFF, 8'h00);
  endtask

  task automatic t_soft_reset();
    wr(ADDR_CFG2, 8'hC7);
    wr(ADDR_CFG3, 8'h87);
    wr(ADDR_CFG1, 8'hE8);
    wr(ADDR_CFG1, 8'hE9);
    cyc(2);
    chk({7'h00, frst}, 8'h01);
    cyc(12);
    wr(ADDR_CFG1, 8'h00);
    rdc(ADDR_CFG1, 8'hFF, 8'h04);
    rdc(ADDR_CFG2, 8'hFF, 8'h00);
    rdc(ADDR_CFG3, 8'hFF, 8'h00);
    rst_pin <= 1'b1;
    cyc(5);
    chk({7'h00, frst}, 8'h01);
    rst_pin <= 1'b0;
    cyc(5);
    chk({7'h00, frst}, 8'h00);
  endtask

  task automatic t_power_down();
    logic [7:0] n;
    tx_run = 1'b1;
    wr(ADDR_CFG1, 8'h02);
    cyc(4);
    chk({7'h00, clk_en}, 8'h00);
    count(2, 60, n);
    chk(n, 8'h00);
    wr(ADDR_CFG1, 8'h03);
    cyc(12);
    chk({7'h00, clk_en}, 8'h01);
    wr(ADDR_CFG1, 8'h00);
    cyc(4);
    chk({7'h00, clk_en}, 8'h01);
  endtask

  task automatic t_line_mode();
    logic [7:0] n;
    logic [7:0] v [3] = '{8'h00, 8'h40, 8'h20};
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_CFG1, v[i]);
      cyc(3);
      chk({7'h00, line_mode_binary}, {7'h00, v[i][5]});
      chk({7'h00, zse}, {7'h00, i == 0});
      count(1, 60, n);
      chk({7'h00, n != 0}, {7'h00, v[i][5]});
    end
  endtask

  task automatic t_ones();
    fmc_rails_s r0;
    wr(ADDR_CFG1, 8'h04);
    cyc(40);
    wait_bit();
    r0 = tx_rail;
    chk({7'h00, r0.pos ^ r0.neg}, 8'h01);
    wait_bit();
    chk({6'h00, tx_rail}, {6'h00, ~r0});
    wr(ADDR_CFG1, 8'h24);
    cyc(40);
    wait_bit();
    chk({6'h00, tx_rail}, 8'h02);
    wr(ADDR_CFG2, 8'h04);
    cyc(40);
    chk({6'h00, rx_line}, 8'h03);
    wait_bit();
    chk({6'h00, tx_rail}, 8'h02);
  endtask

  task automatic t_loops();
    logic [7:0] n;
    wr(ADDR_CFG1, 8'h00);
    wr(ADDR_CFG2, 8'h02);
    cyc(40);
    wait_bit();
    chk({6'h00, tx_rail}, 8'h02);
    count(5, 80, n);
    chk({7'h00, n >= 2}, 8'h01);
    count(4, 80, n);
    chk({7'h00, n != 0}, 8'h01);
    wr(ADDR_CFG2, 8'h06);
    cyc(40);
    wait_bit();
    chk({6'h00, tx_rail}, 8'h02);
    chk({6'h00, rx_line}, 8'h03);
    tx_run = 1'b0;
    tx_pay <= 1'b0;
    wr(ADDR_CFG1, 8'h20);
    wr(ADDR_CFG2, 8'h01);
    cyc(40);
    wait_bit();
    chk({7'h00, fmt_pay}, 8'h01);
    wr(ADDR_CFG2, 8'h00);
    wr(ADDR_CFG3, 8'h02);
    tx_run = 1'b1;
    cyc(40);
    wait_bit();
    chk({7'h00, fmt_pay}, 8'h01);
    wr(ADDR_CFG3, 8'h00);
  endtask

  task automatic t_loss();
    tx_run = 1'b0;
    wr(ADDR_CFG1, 8'h80);
    cyc(130);
    rdc(ADDR_STATUS, 8'h40, 8'h40);
    wait_bit();
    chk({6'h00, tx_rail}, 8'h00);
  endtask

  task automatic t_const_clk();
    logic [7:0] n;
    // drop the clock fallback so the stopped transmit clock is the one selected
    wr(ADDR_CFG1, 8'h00);
    wr(ADDR_CFG2, 8'h40);
    cyc(10);
    chk({7'h00, en_pin}, 8'h00);
    wr(ADDR_CFG3, 8'h01);
    cyc(6);
    chk({7'h00, en_pin}, 8'h01);
    tx_run = 1'b1;
    count(3, 80, n);
    chk({7'h00, n >= 2}, 8'h01);
    wr(ADDR_CFG3, 8'h00);
    wr(ADDR_CFG2, 8'h00);
  endtask

  task automatic t_counters();
    logic [7:0] n;
    wr(ADDR_CFG1, 8'h00);
    tx_run = 1'b0;
    count(0, 200, n);
    chk({7'h00, n != 0}, 8'h01);
    rdc(ADDR_LATCHED, 8'h01, 8'h01);
    wr(ADDR_CFG2, 8'h80);
    count(0, 200, n);
    chk(n, 8'h00);
    tx_run = 1'b1;
    count(0, 200, n);
    chk({7'h00, n != 0}, 8'h01);
    tx_run = 1'b0;
    rx_run = 1'b0;
    cyc(10);
    wr(ADDR_CFG1, 8'h10);
    count(0, 10, n);
    chk(n, 8'h00);
    wr(ADDR_CFG1, 8'h08);
    wr(ADDR_CFG1, 8'h18);
    count(0, 8, n);
    chk(n, 8'h01);
    cyc(10);
    wr(ADDR_CFG1, 8'h08);
    ecu <= 1'b1;
    count(0, 10, n);
    chk(n, 8'h01);
    ecu <= 1'b0;
  endtask

  initial begin
    #300000;
    fails++;
    print_verdict();
  end

  initial begin
    fails    = 0;
    compares = 0;
    RESET_N  = 1'b0;
    bus      = '0;
    rst_pin  = 1'b0;
    tx_run   = 1'b0;
    rx_run   = 1'b1;
    tx_pay   = 1'b0;
    ecu      = 1'b0;
    slot     = 1'b0;
    rx_data  = 2'h2;
    fmt_line = 2'h3;
    fmt_ais  = 2'h0;
    cyc(16);
    RESET_N <= 1'b1;
    t_regs();
    t_soft_reset();
    t_power_down();
    t_ones();
    t_loops();
    t_loss();
    t_const_clk();
    rx_data = 2'h1;
    t_line_mode();
    rx_data = 2'h2;
    t_counters();
    print_verdict();
  end
endmodule
